// ===== core/hpsc_slot_regs.sv
// Hot-plug slot control and status register pair behind an AHB-Lite slave.
// Assumes sensor levels come from pins (synchronised here); cmdDone and
// slotImplemented come from logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module hpsc_slot_regs
	import hpsc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Slot sensors (asynchronous pins)
	input  wire logic        attnButtonPin,
	input  wire logic        powerFaultPin,
	input  wire logic        latchOpenPin,
	input  wire logic        cardPresentPin,
	input  wire logic        presence_strap,
	// Same-domain inputs
	input  wire logic        linkActive,
	input  wire logic        cmdDone,
	input  wire logic        slotImplemented,
	// Slot outputs
	output logic      [1:0]  attnIndicator,
	output logic      [1:0]  powerIndicator,
	output logic             slotPowerOff,
	output logic             attnMsgSend,
	output logic             powerMsgSend,
	output logic             hotplugIrq
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	hpsc_sense_s syncA_q;
	hpsc_sense_s syncB_q;
	hpsc_sense_s prev_q;
	logic        strapA_q;
	logic        strapB_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q  <= '0;
			syncB_q  <= '0;
			strapA_q <= 1'b0;
			strapB_q <= 1'b0;
		end else begin
			syncA_q  <= '{attnButtonPin, powerFaultPin, latchOpenPin, cardPresentPin, 1'b0, 1'b0};
			syncB_q  <= syncA_q;
			strapA_q <= presence_strap;
			strapB_q <= strapA_q;
		end
	end

	// Edge history; a short settle phase after reset captures the strap
	// Three stages so the edge history already holds the pin level when events open
	logic [2:0] settle_q;
	logic       linkPrev_q;
	logic       settled;
	assign settled = settle_q[2];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settle_q   <= 3'h0;
			prev_q     <= '0;
			linkPrev_q <= 1'b0;
		end else begin
			settle_q   <= {settle_q[1:0], 1'b1};
			prev_q     <= syncB_q;
			linkPrev_q <= linkActive;
		end
	end

	// ************************************************************
	// AHB-Lite address phase capture
	// ************************************************************
	logic wrPend_q;
	logic rdPend_q;
	logic addrHit;

	assign addrHit = hsel && hready && htrans == HPSC_HTRANS_NONSEQ && haddr[7:0] == HPSC_SLOT_REG_OFF
		&& haddr[31:8] == 24'h00_0000 && hsize == HPSC_HSIZE_WORD;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
		end else begin
			wrPend_q <= addrHit && hwrite;
			rdPend_q <= addrHit && !hwrite;
		end
	end

	// Zero-wait slave; unmapped reads return zero, writes are dropped
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ************************************************************
	// Control register
	// ************************************************************
	hpsc_ctrl_s ctrl_q;
	logic       attnMsg_q;
	logic       powerMsg_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q         <= '0;
			ctrl_q.attnInd <= HPSC_IND_RST;
			ctrl_q.pwrInd  <= HPSC_IND_RST;
		end else if (wrPend_q) begin
			ctrl_q.abpEn   <= hwdata[HPSC_B_ABP_EN];
			ctrl_q.pfEn    <= hwdata[HPSC_B_PF_EN];
			ctrl_q.pdcEn   <= hwdata[HPSC_B_PDC_EN];
			ctrl_q.ccEn    <= hwdata[HPSC_B_CC_EN];
			ctrl_q.hpEn    <= hwdata[HPSC_B_HP_EN];
			ctrl_q.attnInd <= hwdata[HPSC_B_AIND_LO +: 2];
			ctrl_q.pwrInd  <= hwdata[HPSC_B_PIND_LO +: 2];
			ctrl_q.pwrOff  <= hwdata[HPSC_B_PWR_OFF];
			ctrl_q.dllEn   <= hwdata[HPSC_B_DLL_EN];
		end
	end

	// Each control write emits one pulse per indicator message
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			attnMsg_q  <= 1'b0;
			powerMsg_q <= 1'b0;
		end else begin
			attnMsg_q  <= wrPend_q;
			powerMsg_q <= wrPend_q;
		end
	end

	// ************************************************************
	// Status flags
	// ************************************************************
	logic abp_q;
	logic pf_q;
	logic latchChg_q;
	logic pdc_q;
	logic cc_q;
	logic dllsc_q;
	logic presRst_q;

	// Set beats clear: the event term is ORed after the clear mask
	function automatic logic w1c(input logic cur, input logic evt, input logic clr);
		w1c = evt | (cur & ~clr);
	endfunction : w1c

	logic evAbp;
	logic evPf;
	logic evLatch;
	logic evPdc;
	logic evLink;
	assign evAbp   = settled && syncB_q.attnButton && !prev_q.attnButton;
	assign evPf    = settled && syncB_q.powerFault && !prev_q.powerFault;
	assign evLatch = settled && (syncB_q.latchOpen != prev_q.latchOpen);
	assign evPdc   = settled && (syncB_q.cardPresent != prev_q.cardPresent);
	assign evLink  = settled && (linkActive != linkPrev_q);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			abp_q   <= 1'b0;
			pf_q    <= 1'b0;
			pdc_q   <= 1'b0;
			cc_q    <= 1'b0;
			dllsc_q <= HPSC_DLLSC_RST;
		end else begin
			abp_q   <= w1c(abp_q, evAbp, wrPend_q & hwdata[HPSC_B_ABP]);
			pf_q    <= w1c(pf_q, evPf, wrPend_q & hwdata[HPSC_B_PF]);
			pdc_q   <= w1c(pdc_q, evPdc, wrPend_q & hwdata[HPSC_B_PDC]);
			cc_q    <= w1c(cc_q, cmdDone, wrPend_q & hwdata[HPSC_B_CC]);
			dllsc_q <= w1c(dllsc_q, evLink, wrPend_q & hwdata[HPSC_B_DLLSC]);
		end
	end

	// Read-only change flag: only hardware clears it, on the next read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latchChg_q <= 1'b0;
		end else if (evLatch) begin
			latchChg_q <= 1'b1;
		end else if (rdPend_q) begin
			latchChg_q <= 1'b0;
		end
	end

	// Strap caught once the synchroniser has settled, not in reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			presRst_q <= 1'b0;
		end else if (!settled) begin
			presRst_q <= !strapB_q;
		end
	end

	logic presence;
	always_comb begin
		if (!slotImplemented) begin
			presence = 1'b1;
		end else if (!settled) begin
			presence = presRst_q;
		end else begin
			presence = syncB_q.cardPresent;
		end
	end

	// ************************************************************
	// Read data and outputs
	// ************************************************************
	logic [31:0] rdWord;
	always_comb begin
		rdWord                    = '0;
		rdWord[HPSC_B_ABP_EN]     = ctrl_q.abpEn;
		rdWord[HPSC_B_PF_EN]      = ctrl_q.pfEn;
		rdWord[HPSC_B_PDC_EN]     = ctrl_q.pdcEn;
		rdWord[HPSC_B_CC_EN]      = ctrl_q.ccEn;
		rdWord[HPSC_B_HP_EN]      = ctrl_q.hpEn;
		rdWord[HPSC_B_AIND_LO +: 2] = ctrl_q.attnInd;
		rdWord[HPSC_B_PIND_LO +: 2] = ctrl_q.pwrInd;
		rdWord[HPSC_B_PWR_OFF]    = ctrl_q.pwrOff;
		rdWord[HPSC_B_DLL_EN]     = ctrl_q.dllEn;
		rdWord[HPSC_B_ABP]        = abp_q;
		rdWord[HPSC_B_PF]         = pf_q;
		rdWord[HPSC_B_LATCHCHG]   = latchChg_q;
		rdWord[HPSC_B_PDC]        = pdc_q;
		rdWord[HPSC_B_CC]         = cc_q;
		rdWord[HPSC_B_LATCH]      = settled & syncB_q.latchOpen;
		rdWord[HPSC_B_PRES]       = presence;
		rdWord[HPSC_B_DLLSC]      = dllsc_q;
	end

	logic irqD;
	assign irqD = ctrl_q.hpEn && (
		(ctrl_q.abpEn & abp_q) |
		(ctrl_q.pfEn  & pf_q)  |
		(ctrl_q.pdcEn & pdc_q) |
		(ctrl_q.ccEn  & cc_q)  |
		(ctrl_q.dllEn & dllsc_q));

	logic [31:0] hrdata_q;
	logic        irq_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_q <= 32'h0000_0000;
			irq_q    <= 1'b0;
		end else begin
			hrdata_q <= addrHit && !hwrite ? rdWord : 32'h0000_0000;
			irq_q    <= irqD;
		end
	end

	assign hrdata         = hrdata_q;
	assign hotplugIrq     = irq_q;
	assign attnIndicator  = ctrl_q.attnInd;
	assign powerIndicator = ctrl_q.pwrInd;
	assign slotPowerOff   = ctrl_q.pwrOff;
	assign attnMsgSend    = attnMsg_q;
	assign powerMsgSend   = powerMsg_q;

endmodule : hpsc_slot_regs

`default_nettype wire

// ===== pkg/hpsc_pkg.sv
// Hot-plug slot control/status package: offsets, fields, reset values, types.
// Assumes a single clock domain and an AHB-Lite register port.

package hpsc_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] HPSC_SLOT_REG_OFF = 8'hd8;

	localparam int HPSC_B_ABP_EN   = 0;
	localparam int HPSC_B_PF_EN    = 1;
	localparam int HPSC_B_PDC_EN   = 3;
	localparam int HPSC_B_CC_EN    = 4;
	localparam int HPSC_B_HP_EN    = 5;
	localparam int HPSC_B_AIND_LO  = 6;
	localparam int HPSC_B_PIND_LO  = 8;
	localparam int HPSC_B_PWR_OFF  = 10;
	localparam int HPSC_B_DLL_EN   = 12;
	localparam int HPSC_B_ABP      = 16;
	localparam int HPSC_B_PF       = 17;
	localparam int HPSC_B_LATCHCHG = 18;
	localparam int HPSC_B_PDC      = 19;
	localparam int HPSC_B_CC       = 20;
	localparam int HPSC_B_LATCH    = 21;
	localparam int HPSC_B_PRES     = 22;
	localparam int HPSC_B_DLLSC    = 24;

	localparam logic [1:0] HPSC_IND_RST  = 2'h3;
	localparam logic       HPSC_DLLSC_RST = 1'b1;

	localparam logic [1:0] HPSC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HPSC_HSIZE_WORD    = 3'h2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic       dllEn;
		logic       pwrOff;
		logic [1:0] pwrInd;
		logic [1:0] attnInd;
		logic       hpEn;
		logic       ccEn;
		logic       pdcEn;
		logic       pfEn;
		logic       abpEn;
	} hpsc_ctrl_s;

	typedef struct packed {
		logic attnButton;
		logic powerFault;
		logic latchOpen;
		logic cardPresent;
		logic linkActive;
		logic cmdDone;
	} hpsc_sense_s;

endpackage : hpsc_pkg

// ===== verification/hpsc_slot_model.sv
// Slot hardware model: sensors and the slot power controller.
// Assumes the bench sets wanted sensor levels on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module hpsc_slot_model
	import hpsc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Knobs and power command
	input  wire hpsc_sense_s want,
	input  wire logic        slotPowerOff,
	// Pins
	output hpsc_sense_s      pins
);
	logic       pwrOff_q;
	logic [2:0] busy_q;

	// Sensors lag the knobs a cycle; done pulses once a power change settles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pins     <= {want[5:1], 1'b0};
			pwrOff_q <= 1'b0;
			busy_q   <= 3'h0;
		end else begin
			pins     <= {want[5:1], busy_q == 3'h1};
			pwrOff_q <= slotPowerOff;
			if (pwrOff_q != slotPowerOff) busy_q <= 3'h4;
			else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
		end
	end
endmodule : hpsc_slot_model

`default_nettype wire

// ===== verification/hpsc_slot_regs_properties.sv
// Checker for the slot register pair, watching top-level ports only.
// Assumes hready is the slave's own hreadyout.
`timescale 1ns/10ps
`default_nettype none

module hpsc_slot_regs_properties
	import hpsc_pkg::*;
(
	// Bus
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	// Slot
	input wire logic        slotImplemented,
	input wire logic [1:0]  attnIndicator,
	input wire logic [1:0]  powerIndicator,
	input wire logic        slotPowerOff,
	input wire logic        attnMsgSend,
	input wire logic        powerMsgSend,
	input wire logic        hotplugIrq
);
	logic take, wrTake, rdTake, wrPh_q, hpEn_q;

	assign take = hsel && hready && htrans == HPSC_HTRANS_NONSEQ && hsize == HPSC_HSIZE_WORD
		&& haddr == 32'(HPSC_SLOT_REG_OFF);
	assign wrTake = take && hwrite;
	assign rdTake = take && !hwrite;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Shadow of the master enable, updated on the write data phase edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPh_q <= 1'b0;
			hpEn_q <= 1'b0;
		end else begin
			wrPh_q <= wrTake;
			if (wrPh_q) hpEn_q <= hwdata[HPSC_B_HP_EN];
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	sequence s_wr;
		wrTake ##1 1'b1;
	endsequence

	a_msg_after_write: assert property (s_wr |=> attnMsgSend && powerMsgSend)
		else $error("message pulse missing after write");
	a_msg_has_cause: assert property (attnMsgSend || powerMsgSend |-> $past(wrTake, 2))
		else $error("message pulse without write");
	a_attn_field: assert property (s_wr |=> attnIndicator == $past(hwdata[7:6]))
		else $error("attention indicator not written");
	a_power_field: assert property (s_wr |=> powerIndicator == $past(hwdata[9:8]))
		else $error("power indicator not written");
	a_power_ctrl: assert property (s_wr |=> slotPowerOff == $past(hwdata[10]))
		else $error("slot power command not written");
	a_outputs_hold: assert property (!$past(wrTake, 2) |-> $stable({attnIndicator, powerIndicator, slotPowerOff}))
		else $error("slot outputs moved without write");
	a_irq_master: assert property (hotplugIrq |-> $past(hpEn_q) || $past(hpEn_q, 2))
		else $error("interrupt while master enable off");
	a_rsvd_zero: assert property (rdTake |=> (hrdata & 32'hFE80_E804) == 32'h0000_0000)
		else $error("reserved bits read nonzero");
	a_no_slot: assert property (rdTake && !slotImplemented ##1 !slotImplemented |-> hrdata[HPSC_B_PRES])
		else $error("presence not one without slot");
endmodule : hpsc_slot_regs_properties

bind hpsc_slot_regs hpsc_slot_regs_properties u_props (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
	.hwdata, .hready, .hrdata, .slotImplemented, .attnIndicator, .powerIndicator, .slotPowerOff, .attnMsgSend,
	.powerMsgSend, .hotplugIrq);

`default_nettype wire

// ===== verification/testbench.sv
// Bench for the slot register pair over AHB-Lite with a slot model.
// Assumes zero-wait answers are still waited for on hreadyout.
`timescale 1ns/10ps
`default_nettype none

module testbench
	import hpsc_pkg::*;
;
	localparam logic [31:0] SLOT = 32'h0000_00D8;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic        slotImpl = 1'b1;
	hpsc_sense_s want = 6'b00_0100;
	hpsc_sense_s pins;
	logic [31:0] hrdata, rdv;
	logic [1:0]  attnIndicator, powerIndicator;
	logic        hreadyout, hresp, slotPowerOff, hotplugIrq;
	int          errors = 0;
	int          check_count = 0;

	hpsc_slot_regs dut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(HPSC_HSIZE_WORD), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .attnButtonPin(pins.attnButton),
		.powerFaultPin(pins.powerFault), .latchOpenPin(pins.latchOpen), .cardPresentPin(pins.cardPresent),
		.presence_strap(1'b0), .linkActive(pins.linkActive), .cmdDone(pins.cmdDone), .slotImplemented(slotImpl),
		.attnIndicator, .powerIndicator, .slotPowerOff, .attnMsgSend(), .powerMsgSend(), .hotplugIrq);
	hpsc_slot_model partner (.clk_sys, .rst_n, .want, .slotPowerOff, .pins);

	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		errors++;
		stop_test();
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Entered just after a clock edge; returns at the data phase edge
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= HPSC_HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		r = hrdata;
	endtask : bus

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		bus(1'b0, SLOT, 32'h0000_0000, rdv);
		chk("reset word", 32'h0140_03C0, rdv);
		chk("reset pins", 32'h0000_0078, 32'({attnIndicator, powerIndicator, slotPowerOff, hotplugIrq, hresp}));
		$display("t_reset done");
	endtask : t_reset

	task automatic t_ind();
		logic [31:0] v;
		for (int i = 1; i < 4; i++) begin
			v = 32'(i) << 6 | 32'(4 - i) << 8 | 32'(i & 1) << 10;
			bus(1'b1, SLOT, v, rdv);
			@(negedge clk_sys);
			chk("indicators", v >> 6, 32'({slotPowerOff, powerIndicator, attnIndicator}));
			bus(1'b1, SLOT + 32'h0000_0004, 32'h0000_0000, rdv);
			bus(1'b0, SLOT + 32'h0000_0004, 32'h0000_0000, rdv);
			chk("unmapped read", 32'h0000_0000, rdv);
			bus(1'b0, SLOT, 32'h0000_0000, rdv);
			chk("control", v, {16'h0000, rdv[15:0]});
		end
		$display("t_ind done");
	endtask : t_ind

	task automatic t_events();
		repeat (10) @(posedge clk_sys);
		bus(1'b1, SLOT, 32'hFFFF_FFFF, rdv);
		bus(1'b0, SLOT, 32'h0000_0000, rdv);
		chk("all cleared", 32'h0040_17FB, rdv);
		bus(1'b1, SLOT, 32'h0000_17DB, rdv);
		want <= 6'b11_1010;
		repeat (12) @(posedge clk_sys);
		want.attnButton <= 1'b0;
		chk("irq masked", 32'h0000_0000, 32'(hotplugIrq));
		bus(1'b0, SLOT, 32'h0000_0000, rdv);
		chk("events", 32'h012F_17DB, rdv);
		bus(1'b1, SLOT, 32'h0000_17FB, rdv);
		repeat (3) @(posedge clk_sys);
		chk("irq on", 32'h0000_0001, 32'(hotplugIrq));
		bus(1'b0, SLOT, 32'h0000_0000, rdv);
		chk("zero write", 32'h012B_17FB, rdv);
		bus(1'b1, SLOT, 32'h010B_17FB, rdv);
		repeat (3) @(posedge clk_sys);
		chk("irq cleared", 32'h0000_0000, 32'(hotplugIrq));
		bus(1'b0, SLOT, 32'h0000_0000, rdv);
		chk("after clear", 32'h0020_17FB, rdv);
		bus(1'b1, SLOT, 32'h0000_13FB, rdv);
		repeat (12) @(posedge clk_sys);
		chk("irq command", 32'h0000_0001, 32'(hotplugIrq));
		slotImpl <= 1'b0;
		bus(1'b0, SLOT, 32'h0000_0000, rdv);
		chk("command done", 32'h0070_13FB, rdv);
		$display("t_events done");
	endtask : t_events

	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_ind();
		t_events();
		stop_test();
	end
endmodule : testbench

`default_nettype wire
